/* rtl/cie_consts.svh */
// Opcode, field and vector constants for the instruction category core.
`ifndef CIE_CONSTS_SVH
`define CIE_CONSTS_SVH
`define CIE_OP_BRBIT_HI    4'h0
`define CIE_OP_BITSET_HI   4'h1
`define CIE_OP_REL_HI      4'h2
`define CIE_OP_RMW_DIR     4'h3
`define CIE_OP_RMW_A       4'h4
`define CIE_OP_RMW_X       4'h5
`define CIE_OP_CTL_HI      4'h9
`define CIE_OP_JUMP_LO     4'hc
`define CIE_OP_CALL_LO     4'hd
`define CIE_OP_DIR_ROW     4'hb
`define CIE_OP_EXT_ROW     4'hc
`define CIE_LO_NEG         4'h0
`define CIE_LO_COM         4'h3
`define CIE_LO_LSR         4'h4
`define CIE_LO_ROT_RIGHT   4'h6
`define CIE_LO_ASR         4'h7
`define CIE_LO_SHL         4'h8
`define CIE_LO_ROT_LEFT    4'h9
`define CIE_LO_DEC         4'ha
`define CIE_LO_INC         4'hc
`define CIE_LO_TEST_NZ     4'hd
`define CIE_LO_CLR         4'hf
`define CIE_OP_ACC_TO_IDX  8'h97
`define CIE_OP_IDX_TO_ACC  8'h9f
`define CIE_OP_STOP        8'h8e
`define CIE_OP_WAIT        8'h8f
`define CIE_OP_CLC         8'h98
`define CIE_OP_SEC         8'h99
`define CIE_OP_CLI         8'h9a
`define CIE_OP_SEI         8'h9b
`define CIE_OP_NOP         8'h9d
`define CIE_OP_RTS         8'h81
`define CIE_REL_HC_CLR     4'h8
`define CIE_REL_HC_SET     4'h9
`define CIE_REL_PIN_LOW    4'he
`define CIE_REL_PIN_HIGH   4'hf
`define CIE_PAGE_ZERO      8'h00
`define CIE_RESET_PC       16'h0100
`define CIE_RESET_SP       8'hff
`endif

/* rtl/cie_pkg.sv */
// Types shared by the instruction category core.
package cie_pkg;
	typedef struct packed {
		logic h;
		logic i;
		logic n;
		logic z;
		logic c;
	} cie_ccr_t;

	typedef struct packed {
		logic [15:0] addr;
		logic [7:0]  wdata;
		logic        rd;
		logic        wr;
	} cie_bus_t;

	typedef enum logic [3:0] {
		CIE_FETCH, CIE_OPND1, CIE_OPND2, CIE_READ, CIE_WRITE,
		CIE_PUSH_LO, CIE_PUSH_HI, CIE_POP_HI, CIE_POP_LO, CIE_HALT
	} cie_state_t;
endpackage

/* rtl/cie_core.sv */
// Instruction category core: read-modify-write, bit, branch and control execution.
// Operation
// - Read-modify-write reads, alters, writes back same place.
// - Bit set and clear use direct form only.
// - Test for negative or zero skips write-back.
// - Both left shifts are one identical operation.
// - Rotates pass the bit through carry.
// - False branch condition continues with next instruction.
// - Jumps take target only from operand bytes.
// - Bit branch is opcode, address, offset.
// - Matching bit adds signed offset to next address.
// - Tested bit always copied into carry.
// - Bit branch tests any byte in page zero.
// - Bit set and clear modify any page-zero byte.
// - Stop halts oscillator, enables interrupt pin.
// - Wait halts CPU clock, enables interrupts.
// - Accumulator and index copy into each other.
// - Branches sample interrupt pin high or low.
// - Branches on half-carry clear or set.
// - Direct operands use zero upper address byte.
`timescale 1ns/1ps
`include "cie_consts.svh"
module cie_core (
	input  wire logic              ref_clk,
	input  wire logic              rst_n,
	input  wire logic [7:0]        mem_rdata,
	input  wire logic              irq_pin,
	output cie_pkg::cie_bus_t      mem_bus,
	output cie_pkg::cie_ccr_t      ccr,
	output logic [7:0]             acc,
	output logic [7:0]             idx,
	output logic [15:0]            pc,
	output logic                   osc_stopped,
	output logic                   cpu_clk_halted,
	output logic                   irq_pin_enabled
);
	import cie_pkg::*;

	cie_state_t  st_q;
	cie_ccr_t    ccr_q;
	cie_bus_t    bus_q;
	logic [7:0]  a_q, x_q, sp_q, op_q, b1_q, b2_q;
	logic [15:0] pc_q, ea_q, ret_q;
	logic        stop_q, wait_q;

	wire [3:0] hi = op_q[7:4];
	wire [3:0] lo = op_q[3:0];
	wire is_brbit = (hi == `CIE_OP_BRBIT_HI);
	// Only a direct form exists for bit set and clear, so there is no indexed row to decode.
	wire is_bitsc = (hi == `CIE_OP_BITSET_HI);
	wire is_rel   = (hi == `CIE_OP_REL_HI);
	wire is_rmw_m = (hi == `CIE_OP_RMW_DIR);
	wire is_rmw_r = (hi == `CIE_OP_RMW_A) || (hi == `CIE_OP_RMW_X);
	wire is_jump  = (lo == `CIE_OP_JUMP_LO) && (hi == `CIE_OP_DIR_ROW || hi == `CIE_OP_EXT_ROW);
	wire is_call  = (lo == `CIE_OP_CALL_LO) && (hi == `CIE_OP_DIR_ROW || hi == `CIE_OP_EXT_ROW);
	wire is_ext   = (hi == `CIE_OP_EXT_ROW);

	// Read-modify-write datapath; the operand is memory or a register.
	wire [7:0] rmw_in = is_rmw_m ? mem_rdata : (hi == `CIE_OP_RMW_A) ? a_q : x_q;
	logic [7:0] rmw_out;
	logic       rmw_c;
	logic       rmw_wr;
	always_comb begin
		rmw_out = rmw_in;
		rmw_c   = ccr_q.c;
		rmw_wr  = 1'b1;
		unique case (lo)
			`CIE_LO_NEG: begin
				rmw_out = 8'h00 - rmw_in;
				rmw_c   = (rmw_in != 8'h00);
			end
			`CIE_LO_COM: begin
				rmw_out = ~rmw_in;
				rmw_c   = 1'b1;
			end
			`CIE_LO_LSR: begin
				rmw_out = {1'b0, rmw_in[7:1]};
				rmw_c   = rmw_in[0];
			end
			`CIE_LO_ROT_RIGHT: begin
				rmw_out = {ccr_q.c, rmw_in[7:1]};
				rmw_c   = rmw_in[0];
			end
			`CIE_LO_ASR: begin
				rmw_out = {rmw_in[7], rmw_in[7:1]};
				rmw_c   = rmw_in[0];
			end
			`CIE_LO_SHL: begin
				// One code serves both left shift names, so they cannot diverge.
				rmw_out = {rmw_in[6:0], 1'b0};
				rmw_c   = rmw_in[7];
			end
			`CIE_LO_ROT_LEFT: begin
				rmw_out = {rmw_in[6:0], ccr_q.c};
				rmw_c   = rmw_in[7];
			end
			`CIE_LO_DEC: rmw_out = rmw_in - 8'h01;
			`CIE_LO_INC: rmw_out = rmw_in + 8'h01;
			`CIE_LO_TEST_NZ: rmw_wr = 1'b0;
			`CIE_LO_CLR: rmw_out = 8'h00;
			default: rmw_out = rmw_in;
		endcase
	end

	// Bit test and branch selection.
	wire [2:0] bitno     = op_q[3:1];
	wire       tested    = mem_rdata[bitno];
	wire       want_set  = ~op_q[0];
	wire       bit_taken = (tested == want_set);
	wire [7:0] bitsc_val = op_q[0] ? (mem_rdata & ~(8'h01 << bitno))
	                               : (mem_rdata | (8'h01 << bitno));

	// Relative branch conditions.
	logic rel_cond;
	always_comb begin
		unique case (lo)
			4'h0: rel_cond = 1'b1;
			4'h1: rel_cond = 1'b0;
			4'h2: rel_cond = ~(ccr_q.c | ccr_q.z);
			4'h3: rel_cond = ccr_q.c | ccr_q.z;
			4'h4: rel_cond = ~ccr_q.c;
			4'h5: rel_cond = ccr_q.c;
			4'h6: rel_cond = ~ccr_q.z;
			4'h7: rel_cond = ccr_q.z;
			`CIE_REL_HC_CLR: rel_cond = ~ccr_q.h;
			`CIE_REL_HC_SET: rel_cond = ccr_q.h;
			4'ha: rel_cond = ~ccr_q.n;
			4'hb: rel_cond = ccr_q.n;
			4'hc: rel_cond = ~ccr_q.i;
			4'hd: rel_cond = ccr_q.i;
			`CIE_REL_PIN_LOW: rel_cond = ~irq_pin;
			`CIE_REL_PIN_HIGH: rel_cond = irq_pin;
		endcase
	end

	// Offset byte address plus sign-extended offset; one more gives the taken target.
	wire [15:0] rel_tgt = pc_q + {{8{mem_rdata[7]}}, mem_rdata};
	wire [15:0] pc_inc  = pc_q + 16'h0001;
	wire [15:0] dir_ea  = {`CIE_PAGE_ZERO, mem_rdata};

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			st_q   <= CIE_FETCH;
			ccr_q  <= '{h: 1'b0, i: 1'b1, n: 1'b0, z: 1'b0, c: 1'b0};
			bus_q  <= '{addr: `CIE_RESET_PC, wdata: 8'h00, rd: 1'b1, wr: 1'b0};
			a_q    <= 8'h00;
			x_q    <= 8'h00;
			sp_q   <= `CIE_RESET_SP;
			op_q   <= 8'h00;
			b1_q   <= 8'h00;
			b2_q   <= 8'h00;
			pc_q   <= `CIE_RESET_PC;
			ea_q   <= 16'h0000;
			ret_q  <= 16'h0000;
			stop_q <= 1'b0;
			wait_q <= 1'b0;
		end else begin
			bus_q.wr <= 1'b0;
			bus_q.rd <= 1'b1;
			unique case (st_q)
				CIE_FETCH: begin
					op_q     <= mem_rdata;
					pc_q     <= pc_inc;
					bus_q.addr <= pc_inc;
					st_q     <= CIE_OPND1;
				end
				CIE_OPND1: begin
					st_q <= CIE_FETCH;
					bus_q.addr <= pc_inc;
					pc_q <= pc_inc;
					if (is_brbit || is_bitsc || is_rmw_m) begin
						ea_q       <= dir_ea;
						bus_q.addr <= dir_ea;
						st_q       <= CIE_READ;
					end else if (is_rel) begin
						if (rel_cond) begin
							pc_q       <= rel_tgt + 16'h0001;
							bus_q.addr <= rel_tgt + 16'h0001;
						end
						// A false condition leaves the next sequential address in place.
					end else if (is_jump || is_call) begin
						// The target comes only from operand bytes, never a register.
						b1_q <= mem_rdata;
						if (is_ext) begin
							st_q <= CIE_OPND2;
						end else begin
							ret_q      <= pc_inc;
							pc_q       <= dir_ea;
							bus_q.addr <= dir_ea;
							if (is_call) begin
								ret_q <= pc_inc;
								st_q  <= CIE_PUSH_LO;
								bus_q.addr <= {`CIE_PAGE_ZERO, sp_q};
							end
						end
					end else if (is_rmw_r) begin
						// Register operands are altered and written back in place.
						if (rmw_wr) begin
							if (hi == `CIE_OP_RMW_A) a_q <= rmw_out;
							else x_q <= rmw_out;
						end
						ccr_q.n <= rmw_out[7];
						ccr_q.z <= (rmw_out == 8'h00);
						ccr_q.c <= rmw_c;
						pc_q       <= pc_q;
						bus_q.addr <= pc_q;
					end else begin
						pc_q       <= pc_q;
						bus_q.addr <= pc_q;
						unique case (op_q)
							`CIE_OP_ACC_TO_IDX: x_q <= a_q;
							`CIE_OP_IDX_TO_ACC: a_q <= x_q;
							`CIE_OP_CLC: ccr_q.c <= 1'b0;
							`CIE_OP_SEC: ccr_q.c <= 1'b1;
							`CIE_OP_CLI: ccr_q.i <= 1'b0;
							`CIE_OP_SEI: ccr_q.i <= 1'b1;
							`CIE_OP_STOP: begin
								ccr_q.i  <= 1'b0;
								stop_q   <= 1'b1;
								st_q     <= CIE_HALT;
							end
							`CIE_OP_WAIT: begin
								ccr_q.i  <= 1'b0;
								wait_q   <= 1'b1;
								st_q     <= CIE_HALT;
							end
							`CIE_OP_RTS: begin
								sp_q       <= sp_q + 8'h01;
								bus_q.addr <= {`CIE_PAGE_ZERO, sp_q + 8'h01};
								st_q       <= CIE_POP_HI;
							end
							default: ;
						endcase
					end
				end
				CIE_OPND2: begin
					ret_q      <= pc_inc;
					pc_q       <= {b1_q, mem_rdata};
					bus_q.addr <= {b1_q, mem_rdata};
					st_q       <= CIE_FETCH;
					if (is_call) begin
						bus_q.addr <= {`CIE_PAGE_ZERO, sp_q};
						st_q       <= CIE_PUSH_LO;
					end
				end
				CIE_READ: begin
					if (is_brbit) begin
						// Carry is written here, before the next fetch can test it.
						ccr_q.c    <= tested;
						b2_q       <= mem_rdata;
						bus_q.addr <= pc_q;
						st_q       <= CIE_WRITE;
					end else begin
						bus_q.wdata <= is_bitsc ? bitsc_val : rmw_out;
						bus_q.wr    <= is_bitsc || rmw_wr;
						bus_q.rd    <= 1'b0;
						if (!is_bitsc) begin
							ccr_q.n <= rmw_out[7];
							ccr_q.z <= (rmw_out == 8'h00);
							ccr_q.c <= rmw_c;
						end
						st_q <= CIE_WRITE;
					end
				end
				CIE_WRITE: begin
					if (is_brbit) begin
						// Third byte is the offset; relative to the byte after it.
						pc_q       <= pc_inc;
						bus_q.addr <= pc_inc;
						if (b2_q[bitno] == want_set) begin
							pc_q       <= rel_tgt + 16'h0001;
							bus_q.addr <= rel_tgt + 16'h0001;
						end
					end else begin
						bus_q.addr <= pc_q;
					end
					st_q <= CIE_FETCH;
				end
				CIE_PUSH_LO: begin
					bus_q.wdata <= ret_q[7:0];
					bus_q.addr  <= {`CIE_PAGE_ZERO, sp_q};
					bus_q.wr    <= 1'b1;
					bus_q.rd    <= 1'b0;
					sp_q        <= sp_q - 8'h01;
					st_q        <= CIE_PUSH_HI;
				end
				CIE_PUSH_HI: begin
					bus_q.wdata <= ret_q[15:8];
					bus_q.addr  <= {`CIE_PAGE_ZERO, sp_q};
					bus_q.wr    <= 1'b1;
					bus_q.rd    <= 1'b0;
					sp_q        <= sp_q - 8'h01;
					st_q        <= CIE_WRITE;
				end
				CIE_POP_HI: begin
					b1_q       <= mem_rdata;
					sp_q       <= sp_q + 8'h01;
					bus_q.addr <= {`CIE_PAGE_ZERO, sp_q + 8'h01};
					st_q       <= CIE_POP_LO;
				end
				CIE_POP_LO: begin
					pc_q       <= {mem_rdata, b1_q};
					bus_q.addr <= {mem_rdata, b1_q};
					st_q       <= CIE_FETCH;
				end
				CIE_HALT: begin
					// Only the interrupt pin wakes the core; the vector path lies elsewhere.
					bus_q.rd <= 1'b0;
					if (!irq_pin) begin
						stop_q     <= 1'b0;
						wait_q     <= 1'b0;
						bus_q.addr <= pc_q;
						bus_q.rd   <= 1'b1;
						st_q       <= CIE_FETCH;
					end
				end
			endcase
		end
	end

	assign mem_bus         = bus_q;
	assign ccr             = ccr_q;
	assign acc             = a_q;
	assign idx             = x_q;
	assign pc              = pc_q;
	assign osc_stopped     = stop_q;
	assign cpu_clk_halted  = stop_q | wait_q;
	assign irq_pin_enabled = stop_q | wait_q | ~ccr_q.i;

	property p_tst_nowrite;
		@(posedge ref_clk) disable iff (!rst_n)
		(st_q == CIE_READ && is_rmw_m && lo == `CIE_LO_TEST_NZ) |=> !bus_q.wr;
	endproperty
	a_tst_nowrite: assert property (p_tst_nowrite) else $error("test operation wrote back");

	// Every other memory operation must write its result back to the address it read.
	property p_rmw_wr;
		@(posedge ref_clk) disable iff (!rst_n)
		(st_q == CIE_READ && is_rmw_m && lo != `CIE_LO_TEST_NZ) |=> (bus_q.wr && bus_q.addr == ea_q);
	endproperty
	a_rmw_wr: assert property (p_rmw_wr) else $error("memory result not written back");

	property p_brbit_carry;
		@(posedge ref_clk) disable iff (!rst_n)
		(st_q == CIE_READ && is_brbit) |=> (ccr_q.c == $past(tested));
	endproperty
	a_brbit_carry: assert property (p_brbit_carry) else $error("carry not from tested bit");

	property p_rel_false;
		@(posedge ref_clk) disable iff (!rst_n)
		(st_q == CIE_OPND1 && is_rel && !rel_cond) |=> (pc_q == $past(pc_q) + 16'h0001);
	endproperty
	a_rel_false: assert property (p_rel_false) else $error("false branch moved flow");

	property p_dir_page;
		@(posedge ref_clk) disable iff (!rst_n)
		(st_q == CIE_OPND1 && (is_brbit || is_bitsc)) |=> (bus_q.addr[15:8] == 8'h00);
	endproperty
	a_dir_page: assert property (p_dir_page) else $error("direct operand left page zero");

	property p_stop;
		@(posedge ref_clk) disable iff (!rst_n)
		(st_q == CIE_OPND1 && op_q == `CIE_OP_STOP && !is_rel) |=> (stop_q && irq_pin_enabled);
	endproperty
	a_stop: assert property (p_stop) else $error("stop did not halt");

	property p_wait;
		@(posedge ref_clk) disable iff (!rst_n)
		(st_q == CIE_OPND1 && op_q == `CIE_OP_WAIT) |=> (cpu_clk_halted && !osc_stopped);
	endproperty
	a_wait: assert property (p_wait) else $error("wait state wrong");

	property p_acc_to_idx;
		@(posedge ref_clk) disable iff (!rst_n)
		(st_q == CIE_OPND1 && op_q == `CIE_OP_ACC_TO_IDX) |=> (x_q == $past(a_q));
	endproperty
	a_acc_to_idx: assert property (p_acc_to_idx) else $error("index not loaded from accumulator");

	property p_bitsc_wr;
		@(posedge ref_clk) disable iff (!rst_n)
		(st_q == CIE_READ && is_bitsc) |=> (bus_q.wr && bus_q.addr == ea_q);
	endproperty
	a_bitsc_wr: assert property (p_bitsc_wr) else $error("bit write missing");

	c_brbit: cover property (@(posedge ref_clk) st_q == CIE_READ && is_brbit);
	c_rmw:   cover property (@(posedge ref_clk) st_q == CIE_READ && is_rmw_m && bus_q.rd);
	c_wait:  cover property (@(posedge ref_clk) st_q == CIE_HALT ##1 st_q == CIE_FETCH);
endmodule // cie_core

/* dv/cie_mem_model.sv */
// Behavioural memory, RAM and I/O space that answers the core's internal bus.
`timescale 1ns/1ps
module cie_mem_model (
	input  wire logic         ref_clk,
	input  cie_pkg::cie_bus_t mem_bus,
	output logic [7:0]        mem_rdata
);
	import cie_pkg::*;
	logic [7:0] mem       [0:65535];
	int         zp_writes [0:255];
	logic [7:0] last_q;
	int         hi_writes;

	// Unused space reads as a no-op, so a runaway core drifts instead of stalling.
	initial begin
		last_q = 8'h00;
		hi_writes = 0;
		for (int i = 0; i < 65536; i++) begin
			mem[i] = 8'h9d;
		end
		for (int i = 0; i < 256; i++) begin
			zp_writes[i] = 0;
		end
	end

	// Same-cycle answer; an idle bus shows the inverse of the last byte, never a held copy.
	assign mem_rdata = mem_bus.rd ? mem[mem_bus.addr] : ~last_q;

	always @(posedge ref_clk) begin
		if (mem_bus.rd) begin
			last_q <= mem[mem_bus.addr];
		end
		if (mem_bus.wr) begin
			mem[mem_bus.addr] <= mem_bus.wdata;
			if (mem_bus.addr[15:8] != 8'h00) begin
				hi_writes++;
			end else begin
				zp_writes[mem_bus.addr[7:0]]++;
			end
		end
	end
endmodule // cie_mem_model

/* dv/tb_cie_core.sv */
// Self-checking testbench for the instruction category core.
`timescale 1ns/1ps
module tb_cie_core;
	import cie_pkg::*;
	logic        ref_clk;
	logic        rst_n;
	logic        irq_pin;
	logic [7:0]  mem_rdata;
	cie_bus_t    mem_bus;
	cie_ccr_t    ccr;
	logic [7:0]  acc;
	logic [7:0]  idx;
	logic [15:0] pc;
	logic        osc_stopped;
	logic        cpu_clk_halted;
	logic        irq_pin_enabled;
	int          n_errors;
	int          n_compared;

	initial ref_clk = 1'b0;
	always #2.5 ref_clk = ~ref_clk;

	cie_core u_cie_core (
		.ref_clk         (ref_clk),
		.rst_n           (rst_n),
		.mem_rdata       (mem_rdata),
		.irq_pin         (irq_pin),
		.mem_bus         (mem_bus),
		.ccr             (ccr),
		.acc             (acc),
		.idx             (idx),
		.pc              (pc),
		.osc_stopped     (osc_stopped),
		.cpu_clk_halted  (cpu_clk_halted),
		.irq_pin_enabled (irq_pin_enabled)
	);

	cie_mem_model u_cie_mem_model (
		.ref_clk   (ref_clk),
		.mem_bus   (mem_bus),
		.mem_rdata (mem_rdata)
	);

	task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task test_done;
		$display("mismatches %0d comparisons %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// Waits for pc to reach a value, or for the halt flag to reach t[0].
	task wait_for(input bit on_pc, input logic [15:0] t);
		int k;
		for (k = 0; k < 400; k++) begin
			if (on_pc ? (pc === t) : (cpu_clk_halted === t[0])) begin
				break;
			end
			@(posedge ref_clk);
			#1;
		end
		if (k == 400) begin
			n_errors++;
			$display("[FAIL] wait expected %h", t);
			test_done;
		end
	endtask

	task prog(input logic [15:0] a, input logic [7:0] b[$]);
		foreach (b[i]) begin
			u_cie_mem_model.mem[a + i] = b[i];
		end
	endtask

	task wake;
		@(posedge ref_clk) irq_pin <= 1'b0;
		wait_for(1'b0, 16'h0000);
		@(posedge ref_clk) irq_pin <= 1'b1;
	endtask

	initial begin
		n_errors = 0;
		n_compared = 0;
		rst_n = 1'b0;
		irq_pin = 1'b1;
		#1;
		// The program never applies a read-modify-write to a write-only place.
		prog(16'h0100, '{8'h3c, 8'h10, 8'h38, 8'h11, 8'h39, 8'h12, 8'h36, 8'h13,
			8'h3d, 8'h14, 8'h1e, 8'h20, 8'h11, 8'h20, 8'h0f, 8'h20, 8'h03,
			8'h0e, 8'h20, 8'h02, 8'h3c, 8'h30, 8'h01, 8'h21, 8'h7f});
		prog(16'h0198, '{8'h00, 8'h22, 8'h80});
		prog(16'h011b, '{8'h4f, 8'h4c, 8'h97, 8'h4c, 8'h9f, 8'h28, 8'h02, 8'h3c, 8'h31,
			8'h29, 8'h02, 8'h2e, 8'h02, 8'h2f, 8'h02, 8'h3c, 8'h32, 8'hcc, 8'h02, 8'h00});
		prog(16'h0200, '{8'h8f, 8'h8e, 8'hcc, 8'h02, 8'h02});
		prog(16'h0010, '{8'h7f, 8'hc1, 8'h40, 8'h01, 8'h00});
		prog(16'h0020, '{8'h01, 8'hfe, 8'h01});
		prog(16'h0030, '{8'h55, 8'h55, 8'h55});
		repeat (10) @(posedge ref_clk);
		rst_n <= 1'b1;
		wait_for(1'b1, 16'h0111);
		chk("carry after untaken bit branch", ccr.c, 16'h1);
		chk("bit set then clear", u_cie_mem_model.mem[16'h0020], 16'h80);
		wait_for(1'b1, 16'h0198);
		chk("carry after taken bit branch", ccr.c, 16'h0);
		chk("skipped byte", u_cie_mem_model.mem[16'h0030], 16'h55);
		wait_for(1'b1, 16'h011b);
		chk("carry after backward branch", ccr.c, 16'h1);
		wait_for(1'b1, 16'h012c);
		chk("acc after moves", acc, 16'h1);
		chk("idx after moves", idx, 16'h1);
		chk("half-carry branches", u_cie_mem_model.mem[16'h0031], 16'h55);
		chk("pin level branches", u_cie_mem_model.mem[16'h0032], 16'h55);
		wait_for(1'b0, 16'h0001);
		chk("wait halts clock", cpu_clk_halted, 16'h1);
		chk("wait keeps oscillator", osc_stopped, 16'h0);
		chk("wait enables interrupts", irq_pin_enabled, 16'h1);
		wake;
		wait_for(1'b0, 16'h0001);
		chk("stop halts oscillator", osc_stopped, 16'h1);
		chk("stop enables pin", irq_pin_enabled, 16'h1);
		wake;
		wait_for(1'b1, 16'h0202);
		chk("jump target", pc, 16'h0202);
		chk("increment write-back", u_cie_mem_model.mem[16'h0010], 16'h80);
		chk("single write-back", 16'(u_cie_mem_model.zp_writes[16]), 16'h1);
		chk("left shift", u_cie_mem_model.mem[16'h0011], 16'h82);
		chk("rotate left", u_cie_mem_model.mem[16'h0012], 16'h81);
		chk("rotate right", u_cie_mem_model.mem[16'h0013], 16'h00);
		chk("test writes nothing", 16'(u_cie_mem_model.zp_writes[20]), 16'h0);
		chk("writes outside page zero", 16'(u_cie_mem_model.hi_writes), 16'h0);
		test_done;
	end
endmodule // tb_cie_core
